// ### dv/palette_video_dac_logic_monitor.sv
/* checker on the link between the host end and the converter end.
   assumes one clock and a synchronous active high reset. */
`timescale 1ns/1ns
`default_nettype none
module palette_video_dac_logic_monitor (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [1:0] reg_sel,
	input wire logic wr_n,
	input wire logic rd_n,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic [7:0] mask_out,
	input wire logic [7:0] addr_out
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	// mask resets to all ones; mask and address load on a fresh write strobe
	a_mask_reset: assert property ($fell(rst) |-> mask_out == 8'hff)
		else $error("mask not all ones");
	a_mask_load: assert property ($fell(wr_n) && reg_sel == 2'h2 |=> mask_out == $past(wdata))
		else $error("mask not loaded");
	a_addr_load: assert property ($fell(wr_n) && reg_sel == 2'h0 |=> addr_out == $past(wdata))
		else $error("address not loaded");
	// state holds while no strobe edge occurs
	a_mask_hold: assert property ($stable(wr_n) |=> $stable(mask_out))
		else $error("mask moved");
	a_addr_hold: assert property ($stable(wr_n) && $stable(rd_n) |=> $stable(addr_out))
		else $error("address moved");
	a_rdata_hold: assert property ($stable(rd_n) |=> $stable(rdata))
		else $error("read byte moved");
	// data bytes carry a component in the low six bits
	a_rdata_top: assert property ($fell(rd_n) && reg_sel == 2'h1 |=> ##1 rdata[7:6] == 2'h0)
		else $error("read byte top bits set");
	a_wr_pulse: assert property ($fell(wr_n) |=> wr_n)
		else $error("write strobe too long");
	c_data_wr: cover property ($fell(wr_n) && reg_sel == 2'h1);
	c_data_rd: cover property ($fell(rd_n) && reg_sel == 2'h1);
	c_mask_wr: cover property ($fell(wr_n) && reg_sel == 2'h2);
endmodule
`default_nettype wire

// ### dv/palette_video_dac_logic_tb.sv
/* self-checking bench joining host end and converter end.
   assumes the host end's command handshake and a 100 MHz clock. */
`timescale 1ns/1ns
`default_nettype none
module palette_video_dac_logic_tb;
	import palette_pkg::*;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] pix_in = 8'h00;
	logic cmd_valid = 1'b0;
	logic [1:0] cmd_op = 2'h0;
	logic [7:0] cmd_addr = 8'h00;
	logic [17:0] cmd_entry = 18'h0;
	logic busy, done;
	logic [17:0] rd_entry, colour;
	logic [5:0] red_out, green_out, blue_out;
	logic [7:0] mask_out, addr_out;
	int err_total = 0;
	int check_count = 0;
	logic [7:0] at [4] = '{8'h00, 8'h0a, 8'hff, 8'h5a};
	logic [17:0] et [4] = '{18'h3f001, 18'h0a5c3, 18'h20fc0, 18'h1b2ad};
	// clock and joined ends
	always #5 core_clk = ~core_clk;
	assign colour = {red_out, green_out, blue_out};
	palette_port_if link (.core_clk(core_clk));
	palette_video_dac_logic i_palette_video_dac_logic (.core_clk(core_clk), .rst(rst), .port(link.dev),
		.red_out(red_out), .green_out(green_out), .blue_out(blue_out), .mask_out(mask_out), .addr_out(addr_out));
	palette_host_end i_palette_host_end (.core_clk(core_clk), .rst(rst), .port(link.host), .pix_in(pix_in),
		.cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_entry(cmd_entry),
		.busy(busy), .done(done), .rd_entry(rd_entry));
	palette_video_dac_logic_monitor i_palette_video_dac_logic_monitor (.core_clk(core_clk), .rst(rst),
		.reg_sel(link.reg_sel), .wr_n(link.wr_n), .rd_n(link.rd_n), .wdata(link.wdata), .rdata(link.rdata),
		.mask_out(mask_out), .addr_out(addr_out));
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one host command, waited for under a bound
	task automatic run(input logic [1:0] op, input logic [7:0] a, input logic [17:0] e);
		int n = 0;
		cmd_op = op;
		cmd_addr = a;
		cmd_entry = e;
		cmd_valid = 1'b1;
		@(negedge core_clk);
		cmd_valid = 1'b0;
		while (done !== 1'b1 && n < 100) begin
			@(negedge core_clk);
			n++;
		end
		chk(18'(done), 18'h1);
		repeat (2) @(negedge core_clk);
	endtask
	task automatic settle(input logic [7:0] p, input int k);
		pix_in = p;
		repeat (k) @(negedge core_clk);
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (16) @(negedge core_clk);
		rst = 1'b0;
		@(negedge core_clk);
		chk(18'(mask_out), 18'(MASK_RESET));
		chk(18'(busy), 18'h0);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			run(2'h0, at[i], et[i]);
			chk(18'(addr_out), 18'({at[i] + 8'h01}));
		end
		for (int i = 0; i < 4; i++) begin
			run(2'h1, at[i], 18'h0);
			chk(rd_entry, et[i]);
			chk(18'(addr_out), 18'({at[i] + 8'h01}));
		end
		$display("test entries done");
		settle(8'h00, 8);
		settle(8'h0a, 4);
		chk(colour, et[0]);
		settle(8'h0a, 1);
		chk(colour, et[1]);
		settle(8'h5a, 8);
		run(2'h0, 8'h5a, 18'h2468a);
		settle(8'h5a, 8);
		chk(colour, 18'h2468a);
		$display("test pipeline done");
		run(2'h2, 8'h0f, 18'h0);
		chk(18'(mask_out), 18'h0000f);
		settle(8'h5a, 8);
		chk(colour, et[1]);
		run(2'h2, 8'h00, 18'h0);
		settle(8'hff, 8);
		chk(colour, et[0]);
		$display("test mask done");
		close_out;
	end
	// watchdog against a hung handshake
	initial begin
		#100000;
		err_total++;
		close_out;
	end
endmodule
`default_nettype wire

// ### hw/palette_host_end.sv
/*
 * host end: turns user commands into address, mask and three-byte entry transfers.
 * assumes the converter end shares core_clk; one command at a time while busy is low.
 */
`timescale 1ns/1ns
`default_nettype none
module palette_host_end (
	input wire logic core_clk,
	input wire logic rst,
	palette_port_if.host port,
	input wire logic [palette_pkg::IDX_W-1:0] pix_in,
	input wire logic cmd_valid,
	input wire logic [1:0] cmd_op,
	input wire logic [palette_pkg::IDX_W-1:0] cmd_addr,
	input wire logic [palette_pkg::ENTRY_W-1:0] cmd_entry,
	output logic busy,
	output logic done,
	output logic [palette_pkg::ENTRY_W-1:0] rd_entry
);
	import palette_pkg::*;

	// cmd_op: 0 write entry, 1 read entry, 2 set mask
	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_GAP, ST_DATA, ST_WAIT, ST_TAKE
	} host_st_e;
	host_st_e st_r, st_nxt;
	logic [1:0] cnt_r, cnt_nxt;
	logic is_rd_r, is_rd_nxt, strobe_r, strobe_nxt, done_r, done_nxt, is_mask_r, is_mask_nxt;
	logic [IDX_W-1:0] addr_r, addr_nxt, pix_r;
	logic [ENTRY_W-1:0] ent_r, ent_nxt, rd_r, rd_nxt;
	logic [1:0] sel_r, sel_nxt;
	logic [7:0] wd_r, wd_nxt;

	// sequencer: address write, then three data strobes red-green-blue; a set mask command is a single mask write
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		is_rd_nxt = is_rd_r;
		is_mask_nxt = is_mask_r;
		addr_nxt = addr_r;
		ent_nxt = ent_r;
		rd_nxt = rd_r;
		sel_nxt = sel_r;
		wd_nxt = wd_r;
		strobe_nxt = 1'b0;
		done_nxt = 1'b0;
		case (st_r)
			ST_IDLE: begin
				if (cmd_valid) begin
					is_rd_nxt = (cmd_op == 2'h1);
					is_mask_nxt = (cmd_op == 2'h2);
					addr_nxt = cmd_addr;
					ent_nxt = cmd_entry;
					cnt_nxt = 2'h0;
					st_nxt = ST_ADDR;
				end
			end
			ST_ADDR: begin
				strobe_nxt = 1'b1;
				sel_nxt = is_mask_r ? SEL_MASK : (is_rd_r ? SEL_RD_ADDR : SEL_WR_ADDR);
				wd_nxt = addr_r;
				st_nxt = is_mask_r ? ST_WAIT : ST_GAP;
			end
			ST_GAP: begin
				st_nxt = ST_DATA;
			end
			ST_DATA: begin
				strobe_nxt = 1'b1;
				sel_nxt = SEL_DATA;
				case (cnt_r)
					2'h0: wd_nxt = {2'h0, ent_r[RED_LSB +: COMP_W]};
					2'h1: wd_nxt = {2'h0, ent_r[GRN_LSB +: COMP_W]};
					default: wd_nxt = {2'h0, ent_r[BLU_LSB +: COMP_W]};
				endcase
				st_nxt = ST_WAIT;
			end
			ST_WAIT: begin
				// converter registers the strobe on this edge; its read byte stands after it
				st_nxt = ST_TAKE;
			end
			ST_TAKE: begin
				// read byte taken one clock after the converter acted; gap keeps strobes apart
				if (is_mask_r) begin
					done_nxt = 1'b1;
					st_nxt = ST_IDLE;
				end else begin
					if (is_rd_r) begin
						rd_nxt = {rd_r[ENTRY_W-COMP_W-1:0], port.rdata[COMP_W-1:0]};
					end
					if (cnt_r == PHASE_LAST) begin
						done_nxt = 1'b1;
						st_nxt = ST_IDLE;
					end else begin
						cnt_nxt = cnt_r + 2'h1;
						st_nxt = ST_GAP;
					end
				end
			end
			default: st_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_r <= ST_IDLE;
			cnt_r <= 2'h0;
			is_rd_r <= 1'b0;
			is_mask_r <= 1'b0;
			addr_r <= 8'h00;
			ent_r <= 18'h00000;
			rd_r <= 18'h00000;
			sel_r <= SEL_WR_ADDR;
			wd_r <= 8'h00;
			strobe_r <= 1'b0;
			done_r <= 1'b0;
			pix_r <= 8'h00;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			is_rd_r <= is_rd_nxt;
			is_mask_r <= is_mask_nxt;
			addr_r <= addr_nxt;
			ent_r <= ent_nxt;
			rd_r <= rd_nxt;
			sel_r <= sel_nxt;
			wd_r <= wd_nxt;
			strobe_r <= strobe_nxt;
			done_r <= done_nxt;
			pix_r <= pix_in;
		end
	end

	// strobes idle high; only the selected one pulses low
	assign port.wr_n = !(strobe_r && !(is_rd_r && sel_r == SEL_DATA));
	assign port.rd_n = !(strobe_r && is_rd_r && sel_r == SEL_DATA);
	assign port.reg_sel = sel_r;
	assign port.wdata = wd_r;
	assign port.pix_idx = pix_r;
	assign busy = (st_r != ST_IDLE);
	assign done = done_r;
	assign rd_entry = rd_r;
endmodule
`default_nettype wire

// ### hw/palette_pkg.sv
/*
 * shared constants for the palette video converter logic and its host end.
 * assumes both ends run on one pixel clock with a synchronous active high reset.
 */
package palette_pkg;
	localparam int IDX_W = 8;
	localparam int COMP_W = 6;
	localparam int ENTRY_W = 18;
	localparam int DEPTH = 256;
	localparam int DATA_W = 8;
	// port register select codes
	localparam logic [1:0] SEL_WR_ADDR = 2'h0;
	localparam logic [1:0] SEL_DATA = 2'h1;
	localparam logic [1:0] SEL_MASK = 2'h2;
	localparam logic [1:0] SEL_RD_ADDR = 2'h3;
	// field positions in an entry
	localparam int RED_LSB = 12;
	localparam int GRN_LSB = 6;
	localparam int BLU_LSB = 0;
	localparam logic [7:0] MASK_RESET = 8'hff;
	localparam logic [1:0] PHASE_LAST = 2'h2;
	typedef enum logic [1:0] {
		MODE_WRITE,
		MODE_READ
	} xfer_mode_e;
endpackage

// ### hw/palette_port_if.sv
/*
 * link between host end and converter end: byte port with strobes and pixel index.
 * assumes one shared clock; strobes are active low single cycle pulses.
 */
`timescale 1ns/1ns
`default_nettype none
interface palette_port_if (
	input wire logic core_clk
);
	import palette_pkg::*;
	logic [7:0] pix_idx;
	logic [1:0] reg_sel;
	logic wr_n;
	logic rd_n;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport dev (input pix_idx, input reg_sel, input wr_n, input rd_n, input wdata, output rdata);
	modport host (output pix_idx, output reg_sel, output wr_n, output rd_n, output wdata, input rdata);
endinterface
`default_nettype wire

// ### hw/palette_video_dac_logic.sv
/*
 * converter end: pixel pipeline, palette store, host byte port with staging register.
 * one clock domain: pixel lookup and host access share core_clk.
 * pixel path: index latch, mask stage, palette read, output latch; the colour of an
 * index stands at the outputs three clocks after the index latch takes it.
 * host path: a write to either address select loads the entry address and clears the
 * transfer phase; three data strobes then move red, green and blue through the staging
 * register, and the address steps after the third.
 * reads of the address and mask selects return the stored value; data reads return
 * one component per strobe in the low six bits, top bits zero.
 * the mask resets to all ones so every index passes unchanged until the host loads it.
 * the palette has no reset: an entry reads unknown until the host writes it.
 * assumes the host end shares core_clk and keeps to the three-strobe sequence.
 * assumes strobes idle high and that a strobe held low acts only once.
 */
`timescale 1ns/1ns
`default_nettype none
module palette_video_dac_logic (
	input wire logic core_clk,
	input wire logic rst,
	palette_port_if.dev port,
	output logic [palette_pkg::COMP_W-1:0] red_out,
	output logic [palette_pkg::COMP_W-1:0] green_out,
	output logic [palette_pkg::COMP_W-1:0] blue_out,
	output logic [palette_pkg::IDX_W-1:0] mask_out,
	output logic [palette_pkg::IDX_W-1:0] addr_out
);
	import palette_pkg::*;

	// pixel pipeline stages
	logic [ENTRY_W-1:0] pal_mem [DEPTH];
	logic [IDX_W-1:0] pix_r, pix_nxt;
	logic [IDX_W-1:0] idx_r, idx_nxt;
	logic [ENTRY_W-1:0] look_r, look_nxt;
	logic [ENTRY_W-1:0] out_r, out_nxt;
	// host port state
	logic [IDX_W-1:0] mask_r, mask_nxt;
	logic [IDX_W-1:0] addr_r, addr_nxt;
	logic [1:0] phase_r, phase_nxt;
	logic [ENTRY_W-1:0] stage_r, stage_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	// strobe history for edge detection
	logic wr_d_r, wr_d_nxt;
	logic rd_d_r, rd_d_nxt;
	// one-clock strobe events and palette write enable
	logic wr_pulse, rd_pulse, mem_we;

	// pick component of an entry by transfer phase, red first
	function automatic logic [COMP_W-1:0] comp_of(input logic [ENTRY_W-1:0] e, input logic [1:0] ph);
		case (ph)
			2'h0: comp_of = e[RED_LSB +: COMP_W];
			2'h1: comp_of = e[GRN_LSB +: COMP_W];
			default: comp_of = e[BLU_LSB +: COMP_W];
		endcase
	endfunction

	// replace one component of an entry by transfer phase, red first
	function automatic logic [ENTRY_W-1:0] put_comp(input logic [ENTRY_W-1:0] e, input logic [1:0] ph,
		input logic [COMP_W-1:0] c);
		logic [ENTRY_W-1:0] r;
		r = e;
		case (ph)
			2'h0: r[RED_LSB +: COMP_W] = c;
			2'h1: r[GRN_LSB +: COMP_W] = c;
			default: r[BLU_LSB +: COMP_W] = c;
		endcase
		put_comp = r;
	endfunction

	// next entry address; wraps from the top entry to zero
	function automatic logic [IDX_W-1:0] step_addr(input logic [IDX_W-1:0] a);
		step_addr = a + 8'h01;
	endfunction

	// strobe edges: act once per low pulse
	assign wr_pulse = !port.wr_n && wr_d_r;
	assign rd_pulse = !port.rd_n && rd_d_r;

	// strobe history follows the pins every clock
	always_comb begin
		wr_d_nxt = port.wr_n;
		rd_d_nxt = port.rd_n;
	end

	// pixel pipeline: latch, mask, palette read, output latch
	always_comb begin
		pix_nxt = port.pix_idx;
		idx_nxt = pix_r & mask_r;
		look_nxt = pal_mem[idx_r];
		out_nxt = look_r;
	end

	// host port: address, mask, staging and phase
	always_comb begin
		// hold everything unless a strobe edge arrives
		mask_nxt = mask_r;
		addr_nxt = addr_r;
		phase_nxt = phase_r;
		stage_nxt = stage_r;
		rdata_nxt = rdata_r;
		mem_we = 1'b0;
		if (wr_pulse) begin
			// write strobe decode
			case (port.reg_sel)
				SEL_WR_ADDR: begin
					addr_nxt = port.wdata;
					phase_nxt = 2'h0;
				end
				SEL_RD_ADDR: begin
					addr_nxt = port.wdata;
					phase_nxt = 2'h0;
					// preload the staging register for the first read byte
					stage_nxt = pal_mem[port.wdata];
				end
				SEL_MASK: mask_nxt = port.wdata;
				default: begin
					// data byte lands in the staging register by phase
					stage_nxt = put_comp(stage_r, phase_r, port.wdata[COMP_W-1:0]);
					// third byte completes the entry
					if (phase_r == PHASE_LAST) begin
						mem_we = 1'b1;
						addr_nxt = step_addr(addr_r);
						phase_nxt = 2'h0;
					end else begin
						phase_nxt = phase_r + 2'h1;
					end
				end
			endcase
		end else if (rd_pulse) begin
			// read strobe decode
			case (port.reg_sel)
				SEL_MASK: rdata_nxt = mask_r;
				SEL_WR_ADDR: rdata_nxt = addr_r;
				SEL_RD_ADDR: rdata_nxt = addr_r;
				default: begin
					// return the component selected by the phase
					rdata_nxt = {2'h0, comp_of(stage_r, phase_r)};
					// third byte: step address and preload the next entry
					if (phase_r == PHASE_LAST) begin
						addr_nxt = step_addr(addr_r);
						stage_nxt = pal_mem[step_addr(addr_r)];
						phase_nxt = 2'h0;
					end else begin
						phase_nxt = phase_r + 2'h1;
					end
				end
			endcase
		end
	end

	// palette store has no reset so contents survive a stopped clock
	// host writes may land while the pixel path reads another entry
	always_ff @(posedge core_clk) begin
		if (mem_we) begin
			pal_mem[addr_r] <= stage_nxt;
		end
	end

	// pixel pipeline registers on the pixel clock
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pix_r <= 8'h00;
			idx_r <= 8'h00;
			look_r <= 18'h00000;
			out_r <= 18'h00000;
		end else begin
			pix_r <= pix_nxt;
			idx_r <= idx_nxt;
			look_r <= look_nxt;
			out_r <= out_nxt;
		end
	end

	// host port registers on the pixel clock
	always_ff @(posedge core_clk) begin
		if (rst) begin
			mask_r <= MASK_RESET;
			addr_r <= 8'h00;
			phase_r <= 2'h0;
			stage_r <= 18'h00000;
			rdata_r <= 8'h00;
		end else begin
			mask_r <= mask_nxt;
			addr_r <= addr_nxt;
			phase_r <= phase_nxt;
			stage_r <= stage_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// strobe history resets to the idle high level so no false edge follows reset
	always_ff @(posedge core_clk) begin
		if (rst) begin
			wr_d_r <= 1'b1;
			rd_d_r <= 1'b1;
		end else begin
			wr_d_r <= wr_d_nxt;
			rd_d_r <= rd_d_nxt;
		end
	end

	// outputs straight from registers
	assign port.rdata = rdata_r;
	assign red_out = out_r[RED_LSB +: COMP_W];
	assign green_out = out_r[GRN_LSB +: COMP_W];
	assign blue_out = out_r[BLU_LSB +: COMP_W];
	assign mask_out = mask_r;
	assign addr_out = addr_r;
endmodule
`default_nettype wire
